// File: logic/window_alarm_pkg.sv
// Shared constants and decoding functions for the window alarm monitor.
`default_nettype none
package window_alarm_pkg;
  // ---------------------------------------------------------------------------
  // Channel numbering of the shared result port
  // ---------------------------------------------------------------------------
  localparam int NUM_ANALOG = 4;
  localparam int NUM_TEMP = 3;
  localparam logic [2:0] CH_REMOTE_ONE = 3'h4;
  localparam logic [2:0] CH_REMOTE_TWO = 3'h5;
  localparam logic [2:0] CH_LOCAL_TEMP = 3'h6;

  // ---------------------------------------------------------------------------
  // Status flag layout
  // ---------------------------------------------------------------------------
  localparam int RANGE_BASE = 0;
  localparam int UPPER_BASE = 4;
  localparam int LOWER_BASE = 7;
  localparam int OVERHEAT_POS = 10;
  localparam int DIODE_BASE = 11;
  localparam int NUM_UNITS = 11;
  localparam int NUM_DIODE = 2;
  localparam int NUM_FLAGS = 13;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 13'h0000;

  // ---------------------------------------------------------------------------
  // Widths and fixed limits
  // ---------------------------------------------------------------------------
  localparam int ANALOG_HYS_W = 7;
  localparam int TEMP_HYS_W = 5;
  localparam int QUAL_W = 9;
  localparam logic [QUAL_W-1:0] COUNT_RESET = 9'h000;
  localparam int OVERHEAT_LIMIT_DEG = 150;
  localparam int OVERHEAT_HYS_DEG = 8;

  // ---------------------------------------------------------------------------
  // Qualifier decoding
  // ---------------------------------------------------------------------------
  function automatic logic [QUAL_W-1:0] input_qual_n(input logic [2:0] sel);
    case (sel)
      3'h0: input_qual_n = 9'h001;
      3'h1: input_qual_n = 9'h004;
      3'h2: input_qual_n = 9'h008;
      3'h3: input_qual_n = 9'h010;
      3'h4: input_qual_n = 9'h020;
      3'h5: input_qual_n = 9'h040;
      3'h6: input_qual_n = 9'h080;
      default: input_qual_n = 9'h100;
    endcase
  endfunction : input_qual_n

  function automatic logic [QUAL_W-1:0] temp_qual_n(input logic [1:0] sel);
    case (sel)
      2'h0: temp_qual_n = 9'h001;
      2'h1: temp_qual_n = 9'h002;
      2'h2: temp_qual_n = 9'h004;
      default: temp_qual_n = 9'h008;
    endcase
  endfunction : temp_qual_n
endpackage : window_alarm_pkg
`default_nettype wire

// File: logic/window_alarm_monitor.sv
// Out-of-range alarm monitor with hysteresis, qualifiers, status flags and indicator pin.
`default_nettype none

module window_alarm_monitor
  import window_alarm_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int TEMP_FRAC_BITS = 0
) (
  input wire logic clock, // 250 MHz clock
  input wire logic reset, // Synchronous hardware or power-on reset
  input wire logic soft_reset, // Software reset pulse
  input wire logic result_valid, // One-cycle strobe of a finished conversion
  input wire logic [2:0] result_channel, // Channel of the strobed result
  input wire logic [DATA_W-1:0] result_data, // Analog unsigned, temperature signed
  input wire logic [NUM_ANALOG*DATA_W-1:0] analog_upper_threshold, // Upper bounds
  input wire logic [NUM_ANALOG*DATA_W-1:0] analog_lower_threshold, // Lower bounds
  input wire logic [NUM_ANALOG*ANALOG_HYS_W-1:0] analog_hysteresis, // Analog hysteresis
  input wire logic [NUM_TEMP*DATA_W-1:0] temp_upper_threshold, // Temperature upper limits
  input wire logic [NUM_TEMP*DATA_W-1:0] temp_lower_threshold, // Temperature lower limits
  input wire logic [NUM_TEMP*TEMP_HYS_W-1:0] temp_hysteresis, // Hysteresis in degrees
  input wire logic [2:0] input_qualifier_count_sel, // Analog consecutive-count select
  input wire logic [1:0] temp_qualifier_count_sel, // Temperature consecutive-count select
  input wire logic [NUM_DIODE-1:0] diode_fault, // Remote diode status conditions
  input wire logic local_sensor_powered_down, // Local sensor asleep
  input wire logic sticky_disable, // 1 makes flags follow conditions
  input wire logic [NUM_FLAGS-1:0] indicator_unmask, // 1 lets a flag reach the pin
  input wire logic status_read, // One-cycle pulse: status register read
  output logic [NUM_FLAGS-1:0] status_flags, // Status flags
  output logic global_event_flag, // OR of all status flags
  output logic alarm_out, // Pin output value, always low
  output logic alarm_oe // Pin output enable, high while pulling low
);
  localparam int CW = DATA_W + 2;

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (DATA_W < 10 || DATA_W > 16 || TEMP_FRAC_BITS < 0 || TEMP_FRAC_BITS > 4) begin : bad_params
    $error("window_alarm_monitor: unsupported DATA_W or TEMP_FRAC_BITS");
  end

  localparam logic signed [CW-1:0] OVERHEAT_LIMIT = CW'(OVERHEAT_LIMIT_DEG << TEMP_FRAC_BITS);
  localparam logic signed [CW-1:0] OVERHEAT_CLEAR =
    CW'((OVERHEAT_LIMIT_DEG - OVERHEAT_HYS_DEG) << TEMP_FRAC_BITS);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [NUM_UNITS-1:0] cond_reg;
  logic [NUM_UNITS-1:0] cond_next;
  logic [QUAL_W-1:0] count_reg [NUM_UNITS];
  logic [QUAL_W-1:0] count_next [NUM_UNITS];
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] flags_next;
  logic global_reg;
  logic global_next;
  logic alarm_oe_reg;
  logic alarm_oe_next;
  logic alarm_out_reg;

  // Per-unit view of the current result, also read by the checks.
  logic [NUM_UNITS-1:0] hit_v;
  logic [NUM_UNITS-1:0] out_v;
  logic [NUM_UNITS-1:0] back_v;
  logic [NUM_ANALOG-1:0] inverted_v;

  // ---------------------------------------------------------------------------
  // Window comparison
  // ---------------------------------------------------------------------------
  always_comb begin
    logic signed [CW-1:0] sample_analog;
    logic signed [CW-1:0] sample_temp;
    logic signed [CW-1:0] up;
    logic signed [CW-1:0] lo;
    logic signed [CW-1:0] hy;
    sample_analog = $signed({2'b00, result_data});
    sample_temp = $signed({{2{result_data[DATA_W-1]}}, result_data});
    up = '0;
    lo = '0;
    hy = '0;
    hit_v = '0;
    out_v = '0;
    back_v = '0;
    inverted_v = '0;
    for (int i = 0; i < NUM_ANALOG; i++) begin
      up = $signed({2'b00, analog_upper_threshold[i*DATA_W +: DATA_W]});
      lo = $signed({2'b00, analog_lower_threshold[i*DATA_W +: DATA_W]});
      hy = $signed(CW'(analog_hysteresis[i*ANALOG_HYS_W +: ANALOG_HYS_W]));
      inverted_v[i] = up < lo;
      hit_v[RANGE_BASE+i] = result_valid && (result_channel == 3'(i));
      out_v[RANGE_BASE+i] = sample_analog > up || sample_analog < lo || inverted_v[i];
      back_v[RANGE_BASE+i] = sample_analog <= up - hy && sample_analog >= lo + hy
                             && !inverted_v[i];
    end
    for (int j = 0; j < NUM_TEMP; j++) begin
      up = $signed({{2{temp_upper_threshold[j*DATA_W+DATA_W-1]}},
                    temp_upper_threshold[j*DATA_W +: DATA_W]});
      lo = $signed({{2{temp_lower_threshold[j*DATA_W+DATA_W-1]}},
                    temp_lower_threshold[j*DATA_W +: DATA_W]});
      hy = $signed(CW'(temp_hysteresis[j*TEMP_HYS_W +: TEMP_HYS_W]) <<< TEMP_FRAC_BITS);
      hit_v[UPPER_BASE+j] = result_valid && (result_channel == CH_REMOTE_ONE + 3'(j));
      hit_v[LOWER_BASE+j] = hit_v[UPPER_BASE+j];
      out_v[UPPER_BASE+j] = sample_temp > up;
      back_v[UPPER_BASE+j] = sample_temp <= up - hy;
      out_v[LOWER_BASE+j] = sample_temp < lo;
      back_v[LOWER_BASE+j] = sample_temp >= lo + hy;
    end
    hit_v[OVERHEAT_POS] = result_valid && (result_channel == CH_LOCAL_TEMP);
    out_v[OVERHEAT_POS] = sample_temp > OVERHEAT_LIMIT;
    back_v[OVERHEAT_POS] = sample_temp <= OVERHEAT_CLEAR;
  end

  // ---------------------------------------------------------------------------
  // Qualifier, hysteresis and flag update
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [QUAL_W-1:0] need;
    logic [NUM_FLAGS-1:0] cond_all;
    logic [NUM_FLAGS-1:0] set_event;
    need = '0;
    cond_all = '0;
    set_event = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (u < UPPER_BASE) begin
        need = input_qual_n(input_qualifier_count_sel);
      end else if (u < OVERHEAT_POS) begin
        need = temp_qual_n(temp_qualifier_count_sel);
      end else begin
        need = 9'h001;
      end
      cond_next[u] = cond_reg[u];
      count_next[u] = count_reg[u];
      if (hit_v[u]) begin
        if (out_v[u]) begin
          if (!cond_reg[u]) begin
            if ({1'b0, count_reg[u]} + 10'h001 >= {1'b0, need}) begin
              cond_next[u] = 1'b1;
              count_next[u] = COUNT_RESET;
            end else begin
              count_next[u] = count_reg[u] + 9'h001;
            end
          end
        end else begin
          count_next[u] = COUNT_RESET;
          if (back_v[u]) begin
            cond_next[u] = 1'b0;
          end
        end
      end
    end
    if (local_sensor_powered_down) begin
      cond_next[OVERHEAT_POS] = 1'b0;
      count_next[OVERHEAT_POS] = COUNT_RESET;
    end
    cond_all = {diode_fault, cond_next};
    set_event = {diode_fault, cond_next & hit_v};
    if (sticky_disable) begin
      flags_next = cond_all;
    end else begin
      flags_next = set_event | (flags_reg & ~{NUM_FLAGS{status_read}});
    end
    if (soft_reset) begin
      cond_next = '0;
      for (int u = 0; u < NUM_UNITS; u++) begin
        count_next[u] = COUNT_RESET;
      end
      flags_next = FLAGS_RESET;
    end
    global_next = |flags_next;
    alarm_oe_next = |(flags_next & indicator_unmask);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cond_reg <= '0;
      for (int u = 0; u < NUM_UNITS; u++) begin
        count_reg[u] <= COUNT_RESET;
      end
      flags_reg <= FLAGS_RESET;
      global_reg <= 1'b0;
      alarm_oe_reg <= 1'b0;
      alarm_out_reg <= 1'b0;
    end else begin
      cond_reg <= cond_next;
      for (int u = 0; u < NUM_UNITS; u++) begin
        count_reg[u] <= count_next[u];
      end
      flags_reg <= flags_next;
      global_reg <= global_next;
      alarm_oe_reg <= alarm_oe_next;
      alarm_out_reg <= 1'b0;
    end
  end

  assign status_flags = flags_reg;
  assign global_event_flag = global_reg;
  assign alarm_out = alarm_out_reg;
  assign alarm_oe = alarm_oe_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  global_or_a: assert property (global_reg == |flags_reg)
    else $error("global flag differs from OR of status flags");

  pin_masking_a: assert property (##1 alarm_oe_reg == |(flags_reg & $past(indicator_unmask)))
    else $error("indicator enable does not match unmasked flags");

  pin_never_high_a: assert property (alarm_out_reg == 1'b0)
    else $error("indicator pin driven high");

  read_clears_a: assert property (!sticky_disable && status_read && !result_valid
                                  && diode_fault == '0 |=> flags_reg == '0)
    else $error("status read did not clear flags");

  latched_hold_a: assert property (!sticky_disable && !status_read && !soft_reset
                                   |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("latched flag dropped without a read");

  follow_cond_a: assert property (sticky_disable && !soft_reset
                                  |=> flags_reg[NUM_UNITS-1:0] == cond_reg)
    else $error("unlatched flags do not follow conditions");

  soft_clear_a: assert property (soft_reset |=> flags_reg == '0 && !alarm_oe_reg)
    else $error("software reset left flags set");

  inverted_set_a: assert property (hit_v[3] && inverted_v[3] && !soft_reset
                                   && input_qualifier_count_sel == 3'h0 |=> cond_reg[3])
    else $error("inverted window did not force range condition");

  hyst_hold_a: assert property (cond_reg[0] && hit_v[0] && !back_v[0] && !soft_reset
                                |=> cond_reg[0])
    else $error("range condition cleared inside hysteresis band");

  count_limit_a: assert property (count_reg[0] < input_qual_n(input_qualifier_count_sel)
                                  || $changed(input_qualifier_count_sel)
                                  || $past(input_qualifier_count_sel) != input_qualifier_count_sel
                                  || cond_reg[0])
    else $error("qualifier count passed its limit");

  rise_on_result_a: assert property ($rose(cond_reg[UPPER_BASE]) |-> $past(hit_v[UPPER_BASE]))
    else $error("temperature condition rose without a result");

  overheat_off_a: assert property (local_sensor_powered_down |=> !cond_reg[OVERHEAT_POS])
    else $error("overheat detected while local sensor powered down");
endmodule : window_alarm_monitor
`default_nettype wire

// File: verification/host_model.sv
// Host processor model that answers the open-drain indicator line.
`default_nettype none
module host_model (
  input wire logic clock, // Bench clock
  input wire logic alarm_line, // Resolved indicator wire, pulled up
  input wire logic poll, // Status read asked for by the bench
  input wire logic service_en, // 1 lets the host answer the indicator
  output logic status_read // Status read pulse to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic svc_reg;
  initial svc_reg = 1'b0;
  // A low line is taken as an interrupt and answered by one status read.
  always @(negedge clock) svc_reg <= service_en && !alarm_line && !svc_reg;
  assign status_read = poll | svc_reg;
endmodule : host_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the window alarm monitor.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset = 1, sr = 0, rv = 0, pd = 0, sd = 0, poll = 0, svc = 0;
  logic [2:0] ch = 3'h0, iq = 3'h0;
  logic [1:0] tq = 2'h0, df = 2'h0;
  logic [11:0] rd = 12'h000;
  logic [47:0] au = {12'hFFF, 12'h200, 12'hFFF, 12'h064};
  logic [47:0] al = {12'h000, 12'h000, 12'h010, 12'h00A};
  logic [27:0] ah = {7'h00, 7'h7F, 7'h00, 7'h0A};
  logic [35:0] tu = {3{12'h0C8}}, tl = {3{12'hF9C}};
  logic [14:0] th = {5'h00, 5'h00, 5'h1F};
  logic [12:0] um = 13'h1FFF, flags;
  logic gef, aout, aoe, status_read;
  int fail_count = 0, n_compared = 0;
  // The indicator wire has a pull-up, so a released pin reads high.
  wire logic alarm_line = aoe ? aout : 1'b1;

  window_alarm_monitor DUT (.clock(clock), .reset(reset), .soft_reset(sr), .result_valid(rv),
    .result_channel(ch), .result_data(rd), .analog_upper_threshold(au),
    .analog_lower_threshold(al), .analog_hysteresis(ah), .temp_upper_threshold(tu),
    .temp_lower_threshold(tl), .temp_hysteresis(th), .input_qualifier_count_sel(iq),
    .temp_qualifier_count_sel(tq), .diode_fault(df), .local_sensor_powered_down(pd),
    .sticky_disable(sd), .indicator_unmask(um), .status_read(status_read),
    .status_flags(flags), .global_event_flag(gef), .alarm_out(aout), .alarm_oe(aoe));
  host_model host (.clock(clock), .alarm_line(alarm_line), .poll(poll), .service_en(svc),
    .status_read(status_read));

  initial forever #2 clock = ~clock;

  // ----
  // Drivers and comparisons
  // ----
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_flags(input logic [12:0] exp);
    n_compared++;
    if (flags !== exp || gef !== |exp) begin
      fail_count++;
      $display("wrong value at %0t: flags %h expected %h", $time, flags, exp);
    end
  endtask : chk_flags
  task automatic chk_pin(input logic exp);
    n_compared++;
    if (alarm_line !== exp || aout !== 1'b0) begin
      fail_count++;
      $display("wrong value at %0t: indicator line %b expected %b", $time, alarm_line, exp);
    end
  endtask : chk_pin
  // Sends n back-to-back results; the data lines change once released.
  task automatic strobe(input logic [2:0] c, input logic [11:0] d, input int n);
    repeat (n) begin
      @(negedge clock);
      rv = 1'b1;
      ch = c;
      rd = d;
    end
    @(negedge clock);
    rv = 1'b0;
    rd = ~d;
  endtask : strobe
  task automatic read_status();
    @(negedge clock);
    poll = 1'b1;
    @(negedge clock);
    poll = 1'b0;
  endtask : read_status
  task automatic clear_all();
    @(negedge clock);
    sr = 1'b1;
    @(negedge clock);
    sr = 1'b0;
  endtask : clear_all
  task automatic qual_run(input logic [2:0] c, input logic [11:0] d, input int n,
                          input logic [12:0] e);
    strobe(c, d, n - 1);
    strobe(c, 12'h032, 1);
    strobe(c, d, n - 1);
    chk_flags(13'h0000);
    strobe(c, d, 1);
    chk_flags(e);
    clear_all();
  endtask : qual_run

  // ----
  // Scenarios
  // ----
  task automatic t_window();
    strobe(3'h0, 12'h065, 1);
    chk_flags(13'h0001);
    chk_pin(1'b0);
    strobe(3'h1, 12'h005, 1);
    chk_flags(13'h0003);
    strobe(3'h0, 12'h032, 1);
    chk_flags(13'h0003);
    read_status();
    chk_flags(13'h0000);
    chk_pin(1'b1);
    strobe(3'h1, 12'h005, 1);
    chk_flags(13'h0002);
    clear_all();
    chk_flags(13'h0000);
  endtask : t_window
  task automatic t_hys();
    sd = 1'b1;
    strobe(3'h0, 12'h065, 1);
    strobe(3'h0, 12'h05B, 1);
    chk_flags(13'h0001);
    strobe(3'h0, 12'h05A, 1);
    chk_flags(13'h0000);
    strobe(3'h2, 12'h201, 1);
    strobe(3'h2, 12'h182, 1);
    chk_flags(13'h0004);
    strobe(3'h2, 12'h181, 1);
    chk_flags(13'h0000);
    strobe(3'h4, 12'h0C9, 1);
    strobe(3'h4, 12'h0AA, 1);
    chk_flags(13'h0010);
    strobe(3'h4, 12'h0A9, 1);
    chk_flags(13'h0000);
    strobe(3'h4, 12'hF9B, 1);
    chk_flags(13'h0080);
    strobe(3'h4, 12'hFBB, 1);
    chk_flags(13'h0000);
    sd = 1'b0;
  endtask : t_hys
  task automatic t_invert();
    au[47:36] = 12'h010;
    al[47:36] = 12'h020;
    strobe(3'h3, 12'h018, 1);
    chk_flags(13'h0008);
    read_status();
    strobe(3'h3, 12'h018, 1);
    chk_flags(13'h0008);
    au[47:36] = 12'hFFF;
    al[47:36] = 12'h000;
    clear_all();
  endtask : t_invert
  task automatic t_mask();
    um = 13'h1FFE;
    strobe(3'h0, 12'h065, 1);
    chk_flags(13'h0001);
    chk_pin(1'b1);
    df = 2'b01;
    @(negedge clock);
    chk_flags(13'h0801);
    chk_pin(1'b0);
    df = 2'b00;
    um = 13'h1FFF;
    clear_all();
  endtask : t_mask
  task automatic t_heat();
    sd = 1'b1;
    pd = 1'b1;
    strobe(3'h6, 12'h097, 1);
    chk_flags(13'h0000);
    pd = 1'b0;
    strobe(3'h6, 12'h096, 1);
    chk_flags(13'h0000);
    strobe(3'h6, 12'h097, 1);
    chk_flags(13'h0400);
    strobe(3'h6, 12'h08F, 1);
    chk_flags(13'h0400);
    strobe(3'h6, 12'h08E, 1);
    chk_flags(13'h0000);
    sd = 1'b0;
  endtask : t_heat
  task automatic t_service();
    svc = 1'b1;
    strobe(3'h0, 12'h065, 1);
    for (int i = 0; i < 20 && alarm_line !== 1'b1; i++) @(negedge clock);
    chk_flags(13'h0000);
    chk_pin(1'b1);
    svc = 1'b0;
    clear_all();
  endtask : t_service
  task automatic t_qual_input();
    for (int s = 0; s < 8; s++) begin
      iq = 3'(s);
      qual_run(3'h0, 12'h065, 1 << (s == 0 ? 0 : s + 1), 13'h0001);
    end
    iq = 3'h0;
  endtask : t_qual_input
  task automatic t_qual_temp();
    for (int s = 0; s < 4; s++) begin
      tq = 2'(s);
      qual_run(3'h5, 12'h0C9, 1 << s, 13'h0020);
    end
    tq = 2'h0;
  endtask : t_qual_temp

  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    chk_flags(13'h0000);
    chk_pin(1'b1);
    t_window();
    t_hys();
    t_invert();
    t_mask();
    t_heat();
    t_service();
    t_qual_input();
    t_qual_temp();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
